// ==== src/cw_pkg.sv ====
// Constants, register map and state codes for the call-waiting alert qualifier.
// Assumes a 100 MHz system clock; all times are held in milliseconds.
package cw_pkg;

    // ------------------------------------------------------------
    // Clock and millisecond tick
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 10;
    localparam int MS_NS = 1000000;
    // Clock cycles in one millisecond tick
    localparam int TICK_CYCLES_DEF = MS_NS / CLK_PERIOD_NS;
    localparam int TICK_W = 17;
    localparam int MS_W = 8;
    // Timer saturates here
    localparam logic [MS_W-1:0] MS_MAX = 8'hFF;

    // ------------------------------------------------------------
    // Qualification times in milliseconds
    // ------------------------------------------------------------
    // Built-in set: muting starts on the detect rise
    localparam logic [MS_W-1:0] BUILTIN_MUTE_DELAY_MS = 8'h00;
    localparam logic [MS_W-1:0] BUILTIN_MIN_PULSE_MS = 8'h0F;
    // Adjunct box: muting waits 15 ms
    localparam logic [MS_W-1:0] ADJUNCT_MUTE_DELAY_MS = 8'h0F;
    // Longest time the mute may take to settle
    localparam logic [MS_W-1:0] MUTE_SETTLE_MS = 8'h05;
    localparam logic [MS_W-1:0] PULSE_MARGIN_MS = 8'h0A;
    localparam logic [MS_W-1:0] ADJUNCT_MIN_PULSE_MS =
        ADJUNCT_MUTE_DELAY_MS + MUTE_SETTLE_MS + PULSE_MARGIN_MS;
    // Longest valid alert pulse
    localparam logic [MS_W-1:0] MAX_PULSE_MS = 8'h41;
    // Silence confirmation window and its floor
    localparam logic [MS_W-1:0] CONFIRM_MS = 8'h32;
    localparam logic [MS_W-1:0] MIN_CONFIRM_MS = 8'h1E;
    // End of burst to start of acknowledge
    localparam logic [MS_W-1:0] BURST_TO_ACK_MS = 8'h64;
    // Latest declaration after burst end: 10 ms drop, 5 ms switch, 50 ms window
    localparam logic [MS_W-1:0] LATEST_DECLARE_MS = 8'h41;
    localparam logic [MS_W-1:0] ACK_BUDGET_MS = BURST_TO_ACK_MS - LATEST_DECLARE_MS;
    // Timer value in the finish state at which the budget is spent
    localparam logic [MS_W-1:0] ACK_DEADLINE_MS = CONFIRM_MS + ACK_BUDGET_MS;

    // ------------------------------------------------------------
    // Register map (byte offsets) and fields
    // ------------------------------------------------------------
    localparam int ADDR_W = 4;
    localparam logic [ADDR_W-1:0] REG_CTRL = 4'h0;
    localparam logic [ADDR_W-1:0] REG_STAT = 4'h4;
    localparam logic [ADDR_W-1:0] REG_EVT = 4'h8;
    localparam logic [ADDR_W-1:0] REG_MASK = 4'hC;
    localparam int CTRL_EN = 0;
    localparam int CTRL_ADJ = 1;
    localparam int CTRL_PD = 2;
    localparam int CTRL_DONE = 3;
    localparam int CTRL_W = 3;
    localparam logic [CTRL_W-1:0] CTRL_RESET = 3'h0;
    localparam int STAT_STATE = 0;
    localparam int STAT_MUTE = 3;
    localparam int STAT_FSK = 4;
    localparam int STAT_DET = 5;
    localparam int STAT_LINE = 6;
    localparam int EV_W = 5;
    localparam int EV_VALID = 0;
    localparam int EV_SHORT = 1;
    localparam int EV_LONG = 2;
    localparam int EV_BREAK = 3;
    localparam int EV_LATE = 4;
    localparam logic [EV_W-1:0] EV_NONE = 5'h00;

    // ------------------------------------------------------------
    // Qualifier states
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        S_INITIAL = 3'h0,
        S_MUTE_DELAY_WAIT = 3'h1,
        S_PULSE_MEASURE = 3'h2,
        S_CONFIRM_SILENCE = 3'h3,
        S_FINISH_TRANSACTION = 3'h4,
        S_AWAIT_PULSE_END = 3'h5
    } qual_state_t;

endpackage

// ==== src/qual_if.sv ====
// Interface joining the qualifier core to its timer and detect synchroniser.
// Assumes all three share one clock.
`timescale 1ns/100ps
interface qual_if;
    import cw_pkg::*;
    // Timer clear request and elapsed milliseconds
    logic tmr_clr;
    logic [MS_W-1:0] ms_count;
    // Synchronised detect level and its edges
    logic det_lvl;
    logic det_rise;
    logic det_fall;

    modport timer (input tmr_clr, output ms_count);
    modport sync (output det_lvl, output det_rise, output det_fall);
    modport core (output tmr_clr, input ms_count, input det_lvl, input det_rise,
                  input det_fall);
endinterface // qual_if

// ==== src/ms_timer.sv ====
// Millisecond state timer: a tick divider and a saturating ms counter.
// Assumes a clear pulse from the core restarts both the divider and the count.
`timescale 1ns/100ps
module ms_timer #(
    parameter int TICK_CYCLES = cw_pkg::TICK_CYCLES_DEF
) (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Core side
    qual_if.timer q
);
    import cw_pkg::*;

    // Cycles within the current millisecond
    logic [TICK_W-1:0] div_r;
    logic [MS_W-1:0] ms_r;
    // One-cycle enable at each millisecond
    logic tick;

    assign tick = (div_r == TICK_W'(TICK_CYCLES - 1));
    assign q.ms_count = ms_r;

    // ------------------------------------------------------------
    // Divider and counter
    // ------------------------------------------------------------
    // Clear restarts the phase so a measured time is exact to a tick
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            div_r <= '0;
        end else if (q.tmr_clr || tick) begin
            div_r <= '0;
        end else begin
            div_r <= div_r + TICK_W'(1);
        end
    end

    // Counter stops at its top value instead of wrapping
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ms_r <= '0;
        end else if (q.tmr_clr) begin
            ms_r <= '0;
        end else if (tick && ms_r != MS_MAX) begin
            ms_r <= ms_r + MS_W'(1);
        end
    end

endmodule // ms_timer

// ==== src/det_sync.sv ====
// Two-stage synchroniser for the receiver's detect output, with edge pulses.
// Assumes the detect pin may change at any time relative to clk.
`timescale 1ns/100ps
module det_sync (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Receiver pin
    input wire logic tone_detect_out,
    // Core side
    qual_if.sync q
);
    // First stage, read only by the second
    logic meta_r;
    // Second stage and a delayed copy for edges
    logic lvl_r;
    logic last_r;

    // ------------------------------------------------------------
    // Synchroniser
    // ------------------------------------------------------------
    // Sampled every clock, far finer than the shortest pulse
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            meta_r <= 1'b0;
            lvl_r <= 1'b0;
            last_r <= 1'b0;
        end else begin
            meta_r <= tone_detect_out;
            lvl_r <= meta_r;
            last_r <= lvl_r;
        end
    end

    assign q.det_lvl = lvl_r;
    assign q.det_rise = lvl_r && !last_r;
    assign q.det_fall = !lvl_r && last_r;

endmodule // det_sync

// ==== src/alert_qualifier.sv ====
// Call-waiting alert qualifier: host-side controller beside the tone receiver.
// Assumes an Avalon-MM master, a synchronous clock and an asynchronous receiver.
// Contract
// - Initial: tone mode, timer cleared; rise starts
// - Delay wait: early fall resets; else start muting
// - Fall before minimum pulse: unmute, reset
// - High at 65 ms: unmute, await pulse end
// - Valid-length fall: FSK mode, clear, confirm silence
// - Rise before 50 ms: unmute, tone mode, initial
// - Quiet 50 ms: valid alert, finish transaction
// - Acknowledge starts within 100 ms of burst
// - Finish: unmute, clear, tone mode, initial
// - Await pulse end: on fall clear, initial
// - Built-in: no delay, 5 ms settle, 15 ms
// - Adjunct: 15 ms delay, minimum pulse delay+settle+10
// - Ignore the alert line; qualify on detect only
// - Sample detect faster than every 8 ms
// - Silence window at least 30 ms long
`timescale 1ns/100ps
module alert_qualifier #(
    parameter int TICK_CYCLES = cw_pkg::TICK_CYCLES_DEF
) (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Avalon-MM slave
    input wire logic [cw_pkg::ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Receiver pins
    input wire logic tone_detect_out,
    input wire logic host_alert_line_n,
    output logic fsk_mode_sel,
    output logic power_down_select,
    // Local speech mute
    output logic mute_speech,
    // Interrupt
    output logic irq
);
    import cw_pkg::*;

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    qual_if q ();
    // Qualifier state and its outputs
    qual_state_t state_r, state_nxt;
    logic mute_r, mute_nxt;
    logic fsk_r, fsk_nxt;
    logic late_seen_r;
    // Events raised this cycle
    logic [EV_W-1:0] ev_set;
    // Software registers
    logic [CTRL_W-1:0] ctrl_r;
    logic [EV_W-1:0] evt_r, mask_r;
    // Read answer held one cycle
    logic rvalid_r;
    logic [31:0] rdata_r;
    // Bus decode
    logic wr_ctrl, wr_mask, rd_take, done_pulse;
    // Selected timing set
    logic [MS_W-1:0] mute_delay_ms, min_pulse_ms;
    logic [31:0] rd_mux;

    ms_timer #(.TICK_CYCLES(TICK_CYCLES)) u_timer (
        .clk(clk),
        .resetn(resetn),
        .q(q)
    );

    det_sync u_sync (
        .clk(clk),
        .resetn(resetn),
        .tone_detect_out(tone_detect_out),
        .q(q)
    );

    // ------------------------------------------------------------
    // Bus slave
    // ------------------------------------------------------------
    // Writes finish at once; reads take one wait state for registered data
    assign avs_waitrequest = avs_read && !rvalid_r;
    assign rd_take = avs_read && rvalid_r;
    assign wr_ctrl = avs_write && avs_address == REG_CTRL;
    assign wr_mask = avs_write && avs_address == REG_MASK;
    assign done_pulse = wr_ctrl && avs_writedata[CTRL_DONE];
    assign avs_readdata = rdata_r;

    // Register read mux; unmapped offsets read zero
    always_comb begin
        rd_mux = '0;
        unique case (avs_address)
            REG_CTRL: rd_mux[CTRL_W-1:0] = ctrl_r;
            REG_STAT: begin
                rd_mux[STAT_STATE +: 3] = state_r;
                rd_mux[STAT_MUTE] = mute_r;
                rd_mux[STAT_FSK] = fsk_r;
                rd_mux[STAT_DET] = q.det_lvl;
                // Reported only; never steers qualification
                rd_mux[STAT_LINE] = host_alert_line_n;
            end
            REG_EVT: rd_mux[EV_W-1:0] = evt_r;
            REG_MASK: rd_mux[EV_W-1:0] = mask_r;
            default: rd_mux = '0;
        endcase
    end

    // Read strobe and data capture
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rvalid_r <= 1'b0;
            rdata_r <= '0;
        end else begin
            rvalid_r <= avs_read && !rvalid_r;
            if (avs_read && !rvalid_r) begin
                rdata_r <= rd_mux;
            end
        end
    end

    // Control and mask registers; the done bit is a pulse, not stored
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ctrl_r <= CTRL_RESET;
            mask_r <= EV_NONE;
        end else begin
            if (wr_ctrl) begin
                ctrl_r <= avs_writedata[CTRL_W-1:0];
            end
            if (wr_mask) begin
                mask_r <= avs_writedata[EV_W-1:0];
            end
        end
    end

    // ------------------------------------------------------------
    // Events and interrupt
    // ------------------------------------------------------------
    // Read of the event register clears it; a new event wins over the clear
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            evt_r <= EV_NONE;
        end else if (rd_take && avs_address == REG_EVT) begin
            evt_r <= ev_set;
        end else begin
            evt_r <= evt_r | ev_set;
        end
    end

    assign irq = |(evt_r & mask_r);

    // ------------------------------------------------------------
    // Qualifier state machine
    // ------------------------------------------------------------
    // Timing set chosen by the adjunct bit
    assign mute_delay_ms = ctrl_r[CTRL_ADJ] ? ADJUNCT_MUTE_DELAY_MS
                                            : BUILTIN_MUTE_DELAY_MS;
    assign min_pulse_ms = ctrl_r[CTRL_ADJ] ? ADJUNCT_MIN_PULSE_MS
                                           : BUILTIN_MIN_PULSE_MS;

    // Next state, outputs and timer clears
    always_comb begin
        state_nxt = state_r;
        mute_nxt = mute_r;
        fsk_nxt = fsk_r;
        q.tmr_clr = 1'b0;
        ev_set = EV_NONE;
        unique case (state_r)
            // Tone mode, timer held clear until a rise
            S_INITIAL: begin
                fsk_nxt = 1'b0;
                mute_nxt = 1'b0;
                q.tmr_clr = 1'b1;
                if (ctrl_r[CTRL_EN] && !ctrl_r[CTRL_PD] && q.det_rise) begin
                    state_nxt = S_MUTE_DELAY_WAIT;
                end
            end
            // Ignore pulses shorter than the mute delay
            S_MUTE_DELAY_WAIT: begin
                if (!q.det_lvl) begin
                    q.tmr_clr = 1'b1;
                    state_nxt = S_INITIAL;
                end else if (q.ms_count >= mute_delay_ms) begin
                    mute_nxt = 1'b1;
                    state_nxt = S_PULSE_MEASURE;
                end
            end
            // Measure the muted pulse
            S_PULSE_MEASURE: begin
                if (q.det_fall && q.ms_count < min_pulse_ms) begin
                    mute_nxt = 1'b0;
                    q.tmr_clr = 1'b1;
                    state_nxt = S_INITIAL;
                    ev_set[EV_SHORT] = 1'b1;
                end else if (q.det_fall) begin
                    fsk_nxt = 1'b1;
                    q.tmr_clr = 1'b1;
                    state_nxt = S_CONFIRM_SILENCE;
                end else if (q.ms_count >= MAX_PULSE_MS) begin
                    mute_nxt = 1'b0;
                    state_nxt = S_AWAIT_PULSE_END;
                    ev_set[EV_LONG] = 1'b1;
                end
            end
            // Listen for energy; window length well above its floor
            S_CONFIRM_SILENCE: begin
                if (q.det_rise) begin
                    mute_nxt = 1'b0;
                    fsk_nxt = 1'b0;
                    state_nxt = S_INITIAL;
                    ev_set[EV_BREAK] = 1'b1;
                end else if (q.ms_count >= CONFIRM_MS) begin
                    state_nxt = S_FINISH_TRANSACTION;
                    ev_set[EV_VALID] = 1'b1;
                end
            end
            // Software runs the acknowledge and writes done
            S_FINISH_TRANSACTION: begin
                if (done_pulse) begin
                    mute_nxt = 1'b0;
                    fsk_nxt = 1'b0;
                    q.tmr_clr = 1'b1;
                    state_nxt = S_INITIAL;
                end else if (q.ms_count >= ACK_DEADLINE_MS && !late_seen_r) begin
                    ev_set[EV_LATE] = 1'b1;
                end
            end
            // Too long for an alert; wait for it to end
            S_AWAIT_PULSE_END: begin
                if (!q.det_lvl) begin
                    q.tmr_clr = 1'b1;
                    state_nxt = S_INITIAL;
                end
            end
            default: begin
                state_nxt = S_INITIAL;
                q.tmr_clr = 1'b1;
            end
        endcase
    end

    // State register
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_r <= S_INITIAL;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Mute and receiver mode outputs
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            mute_r <= 1'b0;
            fsk_r <= 1'b0;
        end else begin
            mute_r <= mute_nxt;
            fsk_r <= fsk_nxt;
        end
    end

    // Late acknowledge reported once per transaction
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            late_seen_r <= 1'b0;
        end else if (state_r != S_FINISH_TRANSACTION) begin
            late_seen_r <= 1'b0;
        end else if (ev_set[EV_LATE]) begin
            late_seen_r <= 1'b1;
        end
    end

    assign mute_speech = mute_r;
    assign fsk_mode_sel = fsk_r;
    assign power_down_select = ctrl_r[CTRL_PD];

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    sequence unmute_tone_s;
        !mute_r && !fsk_r;
    endsequence

    sequence fsk_cleared_s;
        fsk_r && state_r == S_CONFIRM_SILENCE ##1 q.ms_count == '0;
    endsequence

    initial_idle_a: assert property (
        state_r == S_INITIAL [*2] |-> !fsk_r && q.ms_count == '0)
        else $error("initial state not idle in tone mode");
    rise_start_a: assert property (
        state_r == S_INITIAL && q.det_rise && ctrl_r[CTRL_EN] && !ctrl_r[CTRL_PD]
        |=> state_r == S_MUTE_DELAY_WAIT ##1 q.ms_count == '0)
        else $error("detect rise did not start timing");
    mute_start_a: assert property (
        state_r == S_MUTE_DELAY_WAIT && q.det_lvl && q.ms_count >= mute_delay_ms
        |=> mute_r && state_r == S_PULSE_MEASURE)
        else $error("muting not started at the mute delay");
    short_drop_a: assert property (
        state_r == S_PULSE_MEASURE && q.det_fall && q.ms_count < min_pulse_ms
        |=> state_r == S_INITIAL and unmute_tone_s)
        else $error("short pulse not rejected");
    long_pulse_a: assert property (
        state_r == S_PULSE_MEASURE && !q.det_fall && q.ms_count >= MAX_PULSE_MS
        |=> state_r == S_AWAIT_PULSE_END && !mute_r)
        else $error("long pulse not rejected at 65 ms");
    fsk_switch_a: assert property (
        state_r == S_PULSE_MEASURE && q.det_fall && q.ms_count >= min_pulse_ms
        |=> fsk_cleared_s)
        else $error("valid pulse did not switch to fsk mode");
    silence_break_a: assert property (
        state_r == S_CONFIRM_SILENCE && q.det_rise
        |=> state_r == S_INITIAL ##0 unmute_tone_s)
        else $error("energy in silence window not handled");
    valid_alert_a: assert property (
        state_r == S_CONFIRM_SILENCE && !q.det_rise && q.ms_count >= CONFIRM_MS
        |=> state_r == S_FINISH_TRANSACTION && evt_r[EV_VALID])
        else $error("quiet window did not declare an alert");
    finish_restore_a: assert property (
        state_r == S_FINISH_TRANSACTION && done_pulse
        |=> state_r == S_INITIAL ##0 unmute_tone_s ##1 q.ms_count == '0)
        else $error("finish did not restore idle");
    await_end_a: assert property (
        state_r == S_AWAIT_PULSE_END && !q.det_lvl |=> state_r == S_INITIAL)
        else $error("await state did not end on low detect");

endmodule // alert_qualifier

// ==== test/rx_model.sv ====
// Behavioural tone receiver: detect and alert pins driven from a burst level.
// Assumes the bench drives burst on clk edges; mode pins come from the qualifier.
`timescale 1ns/100ps
module rx_model #(
    parameter int TICK = 10,
    parameter int DROP_MS = 2
) (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Line and mode
    input wire logic burst,
    input wire logic fsk_mode_sel,
    input wire logic power_down_select,
    // Receiver pins
    output logic tone_detect_out,
    output logic host_alert_line_n
);
    int cnt; // Hold-off left in clocks
    logic fsk_q; // Mode seen one clock ago
    // ----------------------------------------
    // Detect output
    // ----------------------------------------
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            tone_detect_out <= 1'b0;
            cnt <= 0;
            fsk_q <= 1'b0;
        end else begin
            fsk_q <= fsk_mode_sel;
            if (power_down_select || fsk_q != fsk_mode_sel) begin
                // A mode change cuts any pulse short
                tone_detect_out <= 1'b0;
                cnt <= 0;
            end else if (burst) begin
                tone_detect_out <= 1'b1;
                cnt <= fsk_mode_sel ? 8 * TICK : DROP_MS * TICK;
            end else if (cnt != 0) begin
                cnt <= cnt - 1;
            end else begin
                tone_detect_out <= 1'b0;
            end
        end
    end
    // ----------------------------------------
    // Alert line: low from the first detect fall in tone mode
    // ----------------------------------------
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            host_alert_line_n <= 1'b1;
        end else if (power_down_select || fsk_mode_sel) begin
            host_alert_line_n <= 1'b1;
        end else if (tone_detect_out && !burst && cnt == 0) begin
            host_alert_line_n <= 1'b0;
        end
    end
endmodule // rx_model

// ==== test/alert_qualifier_tb.sv ====
// Self-checking bench for the alert qualifier with a behavioural receiver.
// Assumes a 10-clock millisecond tick so every ms figure is ten clocks.
`timescale 1ns/100ps
module alert_qualifier_tb;
    import cw_pkg::*;
    localparam int T = 10; // Clocks per ms
    logic clk, resetn, avs_read, avs_write, avs_waitrequest, burst;
    logic det, alert_n, fsk, pd, mute, irq;
    logic [3:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata, q;
    int err_count, comparisons, cycles;
    alert_qualifier #(.TICK_CYCLES(T)) uut (.clk(clk), .resetn(resetn),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .tone_detect_out(det),
        .host_alert_line_n(alert_n), .fsk_mode_sel(fsk), .power_down_select(pd),
        .mute_speech(mute), .irq(irq));
    rx_model #(.TICK(T)) partner (.clk(clk), .resetn(resetn), .burst(burst),
        .fsk_mode_sel(fsk), .power_down_select(pd), .tone_detect_out(det),
        .host_alert_line_n(alert_n));
    always #5 clk = ~clk;
    // Hang guard
    always @(posedge clk) begin
        cycles++;
        if (cycles == 10000) begin
            err_count++;
            results();
        end
    end
    // ----------------------------------------
    // Bus, compare and timing helpers
    // ----------------------------------------
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= w;
        avs_read <= !w;
        @(posedge clk);
        while (avs_waitrequest !== 1'b0) @(posedge clk);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        comparisons++;
        if (g !== e) begin
            err_count++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic st(input qual_state_t s, input logic m, input logic f);
        bus(1'b0, REG_STAT, 32'h0);
        chk(q & 32'h1F, {27'h0, f, m, s});
        chk({30'h0, fsk, mute}, {30'h0, f, m});
    endtask
    task automatic ev(input logic [31:0] e);
        bus(1'b0, REG_EVT, 32'h0);
        chk(q, e);
    endtask
    task automatic ms(input int n);
        repeat (n * T) @(posedge clk);
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_regs;
        bus(1'b0, REG_CTRL, 32'h0);
        chk(q, 32'h0);
        bus(1'b0, 4'h2, 32'h0);
        chk(q, 32'h0);
        bus(1'b1, REG_MASK, 32'h1F);
        bus(1'b0, REG_MASK, 32'h0);
        chk(q, 32'h1F);
        st(S_INITIAL, 1'b0, 1'b0);
        chk(q & 32'h60, 32'h40);
        bus(1'b1, REG_CTRL, 32'h1);
        $display("registers test done");
    endtask
    task automatic t_valid;
        burst <= 1'b1;
        ms(5);
        st(S_PULSE_MEASURE, 1'b1, 1'b0);
        ms(10);
        burst <= 1'b0;
        ms(4);
        st(S_CONFIRM_SILENCE, 1'b1, 1'b1);
        ms(46);
        st(S_CONFIRM_SILENCE, 1'b1, 1'b1);
        ms(3);
        st(S_FINISH_TRANSACTION, 1'b1, 1'b1);
        chk({31'h0, irq}, 32'h1);
        ev(32'h1 << EV_VALID);
        @(posedge clk);
        chk({31'h0, irq}, 32'h0);
        ms(40);
        ev(32'h1 << EV_LATE);
        bus(1'b1, REG_CTRL, 32'h9);
        st(S_INITIAL, 1'b0, 1'b0);
        $display("valid alert test done");
    endtask
    task automatic t_short;
        burst <= 1'b1;
        ms(12);
        burst <= 1'b0;
        ms(5);
        st(S_INITIAL, 1'b0, 1'b0);
        chk(q & 32'h40, 32'h0);
        ev(32'h1 << EV_SHORT);
        $display("short pulse test done");
    endtask
    task automatic t_long;
        burst <= 1'b1;
        ms(70);
        st(S_AWAIT_PULSE_END, 1'b0, 1'b0);
        ev(32'h1 << EV_LONG);
        burst <= 1'b0;
        ms(5);
        st(S_INITIAL, 1'b0, 1'b0);
        $display("long pulse test done");
    endtask
    task automatic t_break;
        burst <= 1'b1;
        ms(15);
        burst <= 1'b0;
        ms(6);
        burst <= 1'b1;
        @(posedge clk);
        burst <= 1'b0;
        ms(2);
        st(S_INITIAL, 1'b0, 1'b0);
        ev(32'h1 << EV_BREAK);
        ms(15);
        $display("silence break test done");
    endtask
    task automatic t_adj;
        bus(1'b1, REG_CTRL, 32'h3);
        burst <= 1'b1;
        ms(8);
        burst <= 1'b0;
        ms(5);
        st(S_INITIAL, 1'b0, 1'b0);
        burst <= 1'b1;
        ms(10);
        st(S_MUTE_DELAY_WAIT, 1'b0, 1'b0);
        ms(8);
        st(S_PULSE_MEASURE, 1'b1, 1'b0);
        ms(8);
        burst <= 1'b0;
        ms(5);
        ev(32'h1 << EV_SHORT);
        $display("adjunct timing test done");
    endtask
    task automatic t_gate;
        bus(1'b1, REG_CTRL, 32'h5);
        @(posedge clk);
        chk({31'h0, pd}, 32'h1);
        burst <= 1'b1;
        ms(5);
        st(S_INITIAL, 1'b0, 1'b0);
        burst <= 1'b0;
        bus(1'b1, REG_CTRL, 32'h0);
        burst <= 1'b1;
        ms(5);
        st(S_INITIAL, 1'b0, 1'b0);
        burst <= 1'b0;
        $display("gating test done");
    endtask
    task automatic results;
        $display("comparisons %0d, mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    initial begin
        {clk, resetn, avs_read, avs_write, burst, avs_address, avs_writedata} = '0;
        {err_count, comparisons, cycles} = '0;
        repeat (4) @(posedge clk);
        resetn <= 1'b1;
        t_regs;
        t_valid;
        t_short;
        t_long;
        t_break;
        t_adj;
        t_gate;
        results;
    end
endmodule // alert_qualifier_tb
